// *** imuspi_top.sv ***
// imuspi_top: serial register front end of an autonomous inertial sensor
// assumes sensor words come from a processing core on clk_i; link clock is sclk_i
`timescale 1ns/1ns
`default_nettype none
module imuspi_top
  import imuspi_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = IMUSPI_SAMPLE_CYC,
  parameter int unsigned FLASH_CYC = IMUSPI_FLASH_CYC,
  parameter logic [15:0] PRODUCT_ID = 16'h1234 // arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic sample_ready_pin_o,
  input wire imuspi_sens_s sens_i,
  input wire logic [15:0] diag_i,
  output logic [15:0] sample_period_o
);
  // link domain: shift in on rising edge, out on falling edge
  logic [3:0] bit_cnt_r;
  logic [14:0] rx_r;
  logic [15:0] tx_r;
  logic [15:0] tx_load_w;
  logic frame_tgl_r;
  logic [15:0] frame_word_r;
  logic load_pend_r;

  wire [15:0] rx_word_w = {rx_r, mosi_i};
  wire frame_end_w = (bit_cnt_r == 4'(IMUSPI_FRAME_BITS - 1));

  // bit counter restarts when select rises; rst_i also clears it, since select may idle high from power-up
  always_ff @(posedge sclk_i or posedge cs_n_i or posedge rst_i) begin
    if (cs_n_i || rst_i) begin
      bit_cnt_r <= 4'h0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // capture input msb first; hand the complete word over by toggle
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_r <= 15'h0000;
      frame_tgl_r <= 1'b0;
      frame_word_r <= 16'h0000;
    end else if (!cs_n_i) begin
      rx_r <= rx_word_w[14:0];
      if (frame_end_w) begin
        frame_word_r <= rx_word_w;
        frame_tgl_r <= ~frame_tgl_r;
      end
    end
  end

  // load flag: next falling edge after a frame end (or select fall) reloads the shifter
  always_ff @(posedge sclk_i or posedge cs_n_i or posedge rst_i) begin
    if (cs_n_i || rst_i) begin
      load_pend_r <= 1'b1;
    end else begin
      load_pend_r <= frame_end_w;
    end
  end

  // shift out while shifting in, full duplex
  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_r <= 16'h0000;
    end else if (!cs_n_i) begin
      tx_r <= load_pend_r ? tx_load_w : {tx_r[14:0], 1'b0};
    end
  end

  // mode 3: the first falling edge shows the loaded msb; parks low when deselected, no stale bit
  always_ff @(negedge sclk_i or posedge rst_i or posedge cs_n_i) begin
    if (rst_i || cs_n_i) begin
      miso_o <= 1'b0;
    end else begin
      miso_o <= load_pend_r ? tx_load_w[15] : tx_r[14];
    end
  end

  // system domain: toggle synchroniser for frame completion
  logic [2:0] tgl_sync_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tgl_sync_r <= 3'b000;
    end else begin
      tgl_sync_r <= {tgl_sync_r[1:0], frame_tgl_r};
    end
  end
  wire frame_evt_w = tgl_sync_r[2] ^ tgl_sync_r[1];
  // frame_word_r is stable for a whole frame after its toggle, safe to read here
  imuspi_req_s req_w;
  assign req_w = imuspi_req_s'(frame_word_r);

  // sample engine and registers
  imuspi_state_e state_r;
  logic [31:0] smp_cnt_r;
  logic [31:0] wait_cnt_r;
  logic [4:0] drdy_cnt_r;
  imuspi_sens_s outs_r;
  logic [15:0] diag_r;
  logic [15:0] smpl_vol_r;
  logic [15:0] smpl_nv_r = IMUSPI_SMPL_PERIOD_RST; // power-up flash contents
  logic [15:0] resp_r;
  logic [3:0] burst_r;

  wire sample_tick_w = (state_r == IMUSPI_RUN) && (smp_cnt_r == SAMPLE_CYC - 1);
  wire wr_w = frame_evt_w && req_w.write && (burst_r == 4'h0);
  wire wr_smpl_lo_w = wr_w && (req_w.addr == IMUSPI_A_SMPL_PERIOD);
  wire wr_smpl_hi_w = wr_w && (req_w.addr == (IMUSPI_A_SMPL_PERIOD | 7'h01));
  wire flash_go_w = wr_w && (req_w.addr == IMUSPI_A_GLOBAL_CMD) && req_w.data[IMUSPI_GCMD_FLASH_BIT];
  wire burst_go_w = frame_evt_w && !req_w.write && (req_w.addr == IMUSPI_A_GLOBAL_CMD) && (burst_r == 4'h0);
  wire drdy_idle_w = (drdy_cnt_r == 5'h00);

  // read decode on the even word address; low request byte ignored
  logic [15:0] rd_data_w;
  always_comb begin
    unique case ({req_w.addr[6:1], 1'b0})
      IMUSPI_A_RATE_X: rd_data_w = outs_r.rate_x;
      IMUSPI_A_RATE_Y: rd_data_w = outs_r.rate_y;
      IMUSPI_A_RATE_Z: rd_data_w = outs_r.rate_z;
      IMUSPI_A_ACC_X: rd_data_w = outs_r.accel_x;
      IMUSPI_A_ACC_Y: rd_data_w = outs_r.accel_y;
      IMUSPI_A_ACC_Z: rd_data_w = outs_r.accel_z;
      IMUSPI_A_TEMP: rd_data_w = outs_r.temp;
      IMUSPI_A_SMPL_PERIOD: rd_data_w = smpl_vol_r;
      IMUSPI_A_DIAG: rd_data_w = diag_r;
      IMUSPI_A_PROD: rd_data_w = PRODUCT_ID;
      default: rd_data_w = 16'h0000;
    endcase
  end

  // burst word selection in fixed order
  logic [15:0] burst_data_w;
  always_comb begin
    unique case (burst_r)
      4'h8: burst_data_w = diag_r;
      4'h7: burst_data_w = outs_r.rate_x;
      4'h6: burst_data_w = outs_r.rate_y;
      4'h5: burst_data_w = outs_r.rate_z;
      4'h4: burst_data_w = outs_r.accel_x;
      4'h3: burst_data_w = outs_r.accel_y;
      4'h2: burst_data_w = outs_r.accel_z;
      4'h1: burst_data_w = outs_r.temp;
      default: burst_data_w = 16'h0000;
    endcase
  end

  // state: init, run and flash backup; data-ready pulses start only in run
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= IMUSPI_INIT;
      wait_cnt_r <= 32'h0000_0000;
    end else if (state_r == IMUSPI_RUN) begin
      wait_cnt_r <= 32'h0000_0000;
      if (flash_go_w) begin
        state_r <= IMUSPI_FLASH;
      end
    end else if (state_r == IMUSPI_INIT && wait_cnt_r == 32'(IMUSPI_INIT_CYC - 1)) begin
      state_r <= IMUSPI_RUN;
      wait_cnt_r <= 32'h0000_0000;
    end else if (state_r == IMUSPI_FLASH && wait_cnt_r == FLASH_CYC - 1) begin
      state_r <= IMUSPI_RUN;
      wait_cnt_r <= 32'h0000_0000;
    end else begin
      wait_cnt_r <= wait_cnt_r + 32'h0000_0001;
    end
  end

  // fixed-rate sample timer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      smp_cnt_r <= 32'h0000_0000;
    end else if (state_r != IMUSPI_RUN || sample_tick_w) begin
      smp_cnt_r <= 32'h0000_0000;
    end else begin
      smp_cnt_r <= smp_cnt_r + 32'h0000_0001;
    end
  end

  // outputs refresh at the sample tick, while data-ready is low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      outs_r <= '0;
      diag_r <= 16'h0000;
    end else if (sample_tick_w && drdy_idle_w) begin
      outs_r <= sens_i;
      diag_r <= diag_i;
    end
  end

  // data-ready high pulse after each sample cycle
  // ticks come only in run, so pulses stop outside it; one already begun ends at full width
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      drdy_cnt_r <= 5'h00;
      sample_ready_pin_o <= 1'b0;
    end else if (sample_tick_w) begin
      drdy_cnt_r <= 5'(IMUSPI_DRDY_CYC);
      sample_ready_pin_o <= 1'b1;
    end else if (!drdy_idle_w) begin
      drdy_cnt_r <= drdy_cnt_r - 5'h01;
      sample_ready_pin_o <= (drdy_cnt_r != 5'h01);
    end else begin
      sample_ready_pin_o <= 1'b0;
    end
  end

  // nonvolatile copy: like flash it outlives rst_i and changes only at the start of a backup
  always_ff @(posedge clk_i) begin
    if (state_r == IMUSPI_FLASH && wait_cnt_r == 32'h0000_0000) begin
      smpl_nv_r <= smpl_vol_r;
    end
  end

  // working copy takes the default during reset and reloads from saved copy during init
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      smpl_vol_r <= IMUSPI_SMPL_PERIOD_RST;
    end else if (state_r == IMUSPI_INIT) begin
      smpl_vol_r <= smpl_nv_r;
    end else if (wr_smpl_lo_w) begin
      smpl_vol_r[7:0] <= req_w.data;
    end else if (wr_smpl_hi_w) begin
      smpl_vol_r[15:8] <= req_w.data;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sample_period_o <= IMUSPI_SMPL_PERIOD_RST;
    end else begin
      sample_period_o <= smpl_vol_r;
    end
  end

  // response for the next frame: previous request's data, or burst stream
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      resp_r <= 16'h0000;
      burst_r <= 4'h0;
    end else if (frame_evt_w) begin
      if (burst_go_w) begin
        burst_r <= 4'(IMUSPI_BURST_WORDS);
        resp_r <= diag_r;
      end else if (burst_r != 4'h0) begin
        burst_r <= burst_r - 4'h1;
        resp_r <= (burst_r == 4'h1) ? 16'h0000 : burst_data_w;
      end else begin
        resp_r <= req_w.write ? 16'h0000 : rd_data_w;
      end
    end
  end

  // burst is not abandoned when select rises; response index advances only at frame end
  // resp_r is read on the link clock at least a half bit after it settles (<= 2 MHz)
  assign tx_load_w = (burst_r == 4'h0) ? resp_r : burst_data_w;
endmodule
`default_nettype wire

// *** imuspi_pkg.sv ***
// imuspi_pkg: constants and types for the inertial sensor serial register front end
// assumes a 100 MHz system clock; serial link runs on its own clock
package imuspi_pkg;
  localparam int unsigned IMUSPI_CLK_HZ = 100_000_000;
  // sample rate in milli-samples per second (819.2 SPS)
  localparam int unsigned IMUSPI_RATE_MSPS = 819_200;
  localparam int unsigned IMUSPI_SAMPLE_CYC = (IMUSPI_CLK_HZ / IMUSPI_RATE_MSPS) * 1000
    + ((IMUSPI_CLK_HZ % IMUSPI_RATE_MSPS) * 1000) / IMUSPI_RATE_MSPS;
  // flash backup time
  localparam int unsigned IMUSPI_FLASH_MS = 75;
  localparam int unsigned IMUSPI_FLASH_CYC = (IMUSPI_CLK_HZ / 1000) * IMUSPI_FLASH_MS;
  // data ready pulse width in cycles and power-on init time
  localparam int unsigned IMUSPI_DRDY_CYC = 16;
  localparam int unsigned IMUSPI_INIT_CYC = 64;
  localparam int unsigned IMUSPI_FRAME_BITS = 16;
  localparam int unsigned IMUSPI_BURST_WORDS = 8;

  // register byte addresses (low byte address)
  localparam logic [6:0] IMUSPI_A_RATE_X = 7'h04;
  localparam logic [6:0] IMUSPI_A_RATE_Y = 7'h06;
  localparam logic [6:0] IMUSPI_A_RATE_Z = 7'h08;
  localparam logic [6:0] IMUSPI_A_ACC_X = 7'h0A;
  localparam logic [6:0] IMUSPI_A_ACC_Y = 7'h0C;
  localparam logic [6:0] IMUSPI_A_ACC_Z = 7'h0E;
  localparam logic [6:0] IMUSPI_A_TEMP = 7'h18;
  localparam logic [6:0] IMUSPI_A_SMPL_PERIOD = 7'h36;
  localparam logic [6:0] IMUSPI_A_DIAG = 7'h3C;
  localparam logic [6:0] IMUSPI_A_GLOBAL_CMD = 7'h3E;
  localparam logic [6:0] IMUSPI_A_PROD = 7'h56;
  localparam logic [15:0] IMUSPI_SMPL_PERIOD_RST = 16'h0001;
  localparam int unsigned IMUSPI_GCMD_FLASH_BIT = 3;

  // request frame fields
  localparam int unsigned IMUSPI_F_DIR = 15;
  localparam int unsigned IMUSPI_F_ADDR_HI = 14;
  localparam int unsigned IMUSPI_F_ADDR_LO = 8;

  typedef struct packed {
    logic       write;
    logic [6:0] addr;
    logic [7:0] data;
  } imuspi_req_s;

  typedef struct packed {
    logic [15:0] rate_x;
    logic [15:0] rate_y;
    logic [15:0] rate_z;
    logic [15:0] accel_x;
    logic [15:0] accel_y;
    logic [15:0] accel_z;
    logic [15:0] temp;
  } imuspi_sens_s;

  typedef enum logic [1:0] {
    IMUSPI_INIT,
    IMUSPI_RUN,
    IMUSPI_FLASH
  } imuspi_state_e;
endpackage

// *** imuspi_monitor.sv ***
// imuspi_monitor: port-level checks of the serial register front end
// assumes it is bound onto imuspi_top and sees its ports only
`timescale 1ns/1ns
`default_nettype none
module imuspi_monitor
  import imuspi_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = IMUSPI_SAMPLE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic miso_o,
  input wire logic sample_ready_pin_o,
  input wire logic [15:0] sample_period_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int unsigned up_r;
  int unsigned per_r;
  int unsigned hi_r;
  logic seen_r;
  // cycles since reset, since the last ready rise, and of ready high
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      up_r <= 0;
      per_r <= 0;
      hi_r <= 0;
      seen_r <= 1'b0;
    end else begin
      up_r <= (up_r < 32'h0FFFFFFF) ? up_r + 1 : up_r; // saturates, never wraps
      per_r <= (sample_ready_pin_o && hi_r == 0) ? 1 : per_r + 1;
      hi_r <= sample_ready_pin_o ? hi_r + 1 : 0;
      seen_r <= seen_r | sample_ready_pin_o;
    end
  end
  // reset check must stay live while reset is high
  AST_RST_OUT: assert property (disable iff (1'b0) rst_i |-> sample_period_o == IMUSPI_SMPL_PERIOD_RST
    && !miso_o && !sample_ready_pin_o) else $error("outputs not at reset values");
  AST_READY_ON: assert property ($rose(sample_ready_pin_o) |-> sample_ready_pin_o[*8])
    else $error("ready pulse too short");
  AST_READY_W: assert property ($fell(sample_ready_pin_o) |-> hi_r == IMUSPI_DRDY_CYC)
    else $error("ready pulse width wrong");
  AST_RATE: assert property ($rose(sample_ready_pin_o) && seen_r |-> per_r >= SAMPLE_CYC)
    else $error("ready pulses closer than the sample period");
  AST_INIT_QUIET: assert property (up_r < IMUSPI_INIT_CYC + SAMPLE_CYC - 2 |-> !sample_ready_pin_o)
    else $error("ready pulse during start-up");
  AST_FIRST: assert property (up_r == IMUSPI_INIT_CYC + SAMPLE_CYC + 8 |-> seen_r)
    else $error("no ready pulse after start-up");
  AST_MISO_EDGE: assert property ($changed(miso_o) && !cs_n_i && !$past(cs_n_i) |-> !sclk_i)
    else $error("serial output moved while clock high");
  AST_MISO_IDLE: assert property (cs_n_i[*8] |-> !miso_o)
    else $error("serial output not low while deselected");
endmodule
bind imuspi_top imuspi_monitor #(.SAMPLE_CYC(SAMPLE_CYC)) imuspi_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
  .sclk_i(sclk_i), .cs_n_i(cs_n_i), .miso_o(miso_o), .sample_ready_pin_o(sample_ready_pin_o),
  .sample_period_o(sample_period_o));
`default_nettype wire

// *** imuspi_master.sv ***
// imuspi_master: serial master on the far side, mode 3, 16-bit frames
// assumes the testbench calls xfer; clock edges drift against clk_i
`timescale 1ns/1ns
`default_nettype none
module imuspi_master (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  // idle: clock high, select high
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // one frame; gap below zero keeps select low for a burst
  // the 125 ns bench clock is faster than a real master may run (2 MHz, 1 MHz in burst)
  task automatic xfer(input logic [15:0] tx, input int gap, output logic [15:0] rx);
    cs_n_o = 1'b0; // select settles well before the first clock edge
    #52;
    for (int i = 15; i >= 0; i--) begin
      sclk_o = 1'b0;
      mosi_o = tx[i];
      #61 sclk_o = 1'b1;
      rx[i] = miso_i;
      #64;
    end
    mosi_o = ~mosi_o; // released line must not show the last bit
    if (gap >= 0) begin
      #20 cs_n_o = 1'b1;
      #(gap);
    end
  endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// tb: reads, burst, byte writes and flash backup through the serial master
// assumes shortened sample and flash counts so the run stays short
`timescale 1ns/1ns
`default_nettype none
module tb;
  import imuspi_pkg::*;
  localparam logic [15:0] PID = 16'h2A5C; // arbitrary value
  localparam int G = 20000; // select-high gap between ordinary frames, ns
  // clock starts high and reset low, so reset rises as an edge before the first rising clock
  logic clk_i = 1'b1;
  logic rst_i = 1'b0;
  wire logic sclk, cs_n, mosi, miso, rdy;
  wire logic [15:0] sp;
  imuspi_sens_s sens = '{16'hA101, 16'hA202, 16'hA303, 16'hB404, 16'hB505, 16'hB606, 16'hC707};
  logic [15:0] diag = 16'h0E5A;
  logic [15:0] rx;
  logic [15:0] ev [10];
  logic [6:0] ad [10] = '{IMUSPI_A_RATE_X, IMUSPI_A_RATE_Y, IMUSPI_A_RATE_Z, IMUSPI_A_ACC_X,
    IMUSPI_A_ACC_Y, IMUSPI_A_ACC_Z, IMUSPI_A_TEMP, IMUSPI_A_DIAG, IMUSPI_A_PROD, 7'h10};
  int n_mismatch = 0;
  int compares = 0;
  always #5 clk_i = ~clk_i;
  imuspi_top #(.SAMPLE_CYC(200), .FLASH_CYC(300), .PRODUCT_ID(PID)) imuspi_top_i (.clk_i(clk_i),
    .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
    .sample_ready_pin_o(rdy), .sens_i(sens), .diag_i(diag), .sample_period_o(sp));
  imuspi_master imuspi_master_i (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // bounded wait for the next ready pulse
  task automatic wait_rdy;
    int i;
    for (i = 0; i < 9000 && rdy !== 1'b1; i++) @(negedge clk_i);
    if (i == 9000) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t no ready pulse", $time);
      print_verdict;
    end
  endtask
  task automatic do_reset;
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (8) @(negedge clk_i);
    chk(sp, 16'h0001);
    chk({14'h0, miso, rdy}, 16'h0000);
    rst_i = 1'b0;
  endtask
  task automatic x(input logic [15:0] w, input int gap);
    imuspi_master_i.xfer(w, gap, rx);
  endtask
  initial begin
    int hi;
    ev = '{sens.rate_x, sens.rate_y, sens.rate_z, sens.accel_x, sens.accel_y, sens.accel_z,
      sens.temp, diag, PID, 16'h0000};
    do_reset;
    wait_rdy;
    x(16'h5600, G);
    x(16'h5600, G);
    chk(rx, PID);
    // back-to-back single reads, each answer one frame late
    for (int k = 0; k <= 10; k++) begin
      x({1'b0, ad[k % 10], 8'h00}, G);
      if (k > 0) chk(rx, ev[k - 1]);
    end
    x(16'h3E00, -1);
    for (int k = 0; k < 8; k++) begin
      x(16'h0000, (k < 7) ? -1 : G);
      chk(rx, ev[(k + 7) % 8]);
    end
    x(16'hB704, G);
    chk(sp, 16'h0401);
    x(16'hB622, G);
    chk(sp, 16'h0422);
    x(16'h3600, G);
    x(16'h0000, G);
    chk(rx, 16'h0422);
    // no backup taken, so reset restores the saved value
    do_reset;
    wait_rdy;
    chk(sp, 16'h0001);
    // back up a changed period; no traffic while the backup runs, ready must stay low
    x(16'hB704, G);
    x(16'hBE08, 200);
    hi = 0;
    repeat (250) begin
      @(negedge clk_i);
      if (rdy !== 1'b0) hi++;
    end
    chk(hi[15:0], 16'h0000);
    wait_rdy;
    // the saved copy outlives reset and is reloaded into the working copy
    do_reset;
    wait_rdy;
    chk(sp, 16'h0401);
    print_verdict;
  end
endmodule
`default_nettype wire
